// ===== verilog/cmp_ctrl_pkg.sv
`default_nettype none
package cmp_ctrl_pkg;

  // ==========================================================
  // register indexes on the plain register port
  localparam logic [3:0] ADDR_CMP0_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_CMP2_CONTROL   = 4'h1;
  localparam logic [3:0] ADDR_STATUS         = 4'h2;
  localparam logic [3:0] ADDR_DISABLE_A      = 4'h3;
  localparam logic [3:0] ADDR_DISABLE_B      = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLEAR      = 4'h6;
  localparam logic [3:0] ADDR_IRQ_ENABLE     = 4'h7;

  // ==========================================================
  // control register fields
  localparam int CTL_ON_BIT     = 7;
  localparam int CTL_IRQ_ON_BIT = 6;
  localparam int CTL_EDGE_HI    = 5;
  localparam int CTL_EDGE_LO    = 4;
  localparam int CTL_NEG_HI     = 2;
  localparam int CTL_NEG_LO     = 0;
  localparam logic [7:0] CTL_WMASK = 8'hF7;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // status register fields
  localparam int ST_HALVE_BIT = 7;
  localparam int ST_FLAG2_BIT = 6;
  localparam int ST_FLAG0_BIT = 5;
  localparam int ST_LIVE2_BIT = 2;
  localparam int ST_LIVE0_BIT = 0;

  // ==========================================================
  // pin disable fields
  localparam int DIS_NEG_PIN_BIT  = 3;
  localparam int DIS_CMP2_PIN_BIT = 2;
  localparam int DIS_CMP0_PIN_BIT = 5;
  localparam logic [7:0] DIS_B_WMASK = 8'h38;

  // ==========================================================
  // irq event bits
  localparam int EV_CMP0 = 0;
  localparam int EV_CMP2 = 1;
  localparam int EV_W    = 2;

  typedef enum logic [1:0] {
    EDGE_TOGGLE   = 2'b00,
    EDGE_RESERVED = 2'b01,
    EDGE_FALL     = 2'b10,
    EDGE_RISE     = 2'b11
  } edge_sel_t;

  typedef enum logic [2:0] {
    NEG_REF_640  = 3'b000,
    NEG_REF_320  = 3'b001,
    NEG_REF_213  = 3'b010,
    NEG_REF_160  = 3'b011,
    NEG_EXT_PIN  = 3'b100,
    NEG_DAC      = 3'b101,
    NEG_RSV_6    = 3'b110,
    NEG_RSV_7    = 3'b111
  } neg_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // one-hot negative input route: ref640,ref320,ref213,ref160,ext,dac
  typedef struct packed {
    logic dac;
    logic ext;
    logic ref160;
    logic ref213;
    logic ref320;
    logic ref640;
  } neg_route_t;

endpackage : cmp_ctrl_pkg
`default_nettype wire

// ===== verilog/cmp_channel.sv
`timescale 1ns/1ns
`default_nettype none
module cmp_channel #(
  parameter bit HAS_DAC = 1'b0
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    sample_en,
  input  wire logic                    cmp_on,
  input  wire logic [1:0]              edge_sel,
  input  wire logic [2:0]              neg_sel,
  input  wire logic                    raw_out,
  output logic                         live_q,
  output logic                         event_pulse,
  output cmp_ctrl_pkg::neg_route_t     route
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic live_d;
  logic rise;
  logic fall;

  // ==========================================================
  // synchroniser, change counts when stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_out;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign live_d = (sample_en && (sync2_q == sync3_q)) ? sync3_q : live_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      live_q <= 1'b0;
    else if (!cmp_on)
      live_q <= 1'b0;
    else
      live_q <= live_d;
  end

  assign rise = cmp_on && !live_q && live_d;
  assign fall = cmp_on && live_q && !live_d;

  assign event_pulse =
    (edge_sel == cmp_ctrl_pkg::EDGE_TOGGLE) ? (rise | fall) :
    (edge_sel == cmp_ctrl_pkg::EDGE_FALL)   ? fall :
    (edge_sel == cmp_ctrl_pkg::EDGE_RISE)   ? rise : 1'b0;

  assign route.ref640 = cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_REF_640);
  assign route.ref320 = cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_REF_320);
  assign route.ref213 = cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_REF_213);
  assign route.ref160 = cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_REF_160);
  assign route.ext    = cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_EXT_PIN);
  assign route.dac    = HAS_DAC && cmp_on && (neg_sel == cmp_ctrl_pkg::NEG_DAC);

  // ==========================================================
  // assertions
  reserved_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (edge_sel == cmp_ctrl_pkg::EDGE_RESERVED) |-> !event_pulse)
    else $error("reserved edge code raised an event");

  off_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cmp_on |=> !live_q)
    else $error("disabled comparator shows a live output");

endmodule : cmp_channel
`default_nettype wire

// ===== verilog/analog_comparator_control.sv
// Function
// - control bit 7 enables the comparator
// - control bit 6 gates interrupt request
// - edge selector: toggle, reserved, fall, rise
// - comparator 0 negative input mux decode
// - comparator 2 adds dac at 101
// - divider bit halves comparison clock
// - status bit 6 flags comparator 2 events
// - status bit 5 flags comparator 0 events
// - vector entry clears flag if irq enabled
// - writing one clears flag, zero keeps
// - flags drive conversion triggers always
// - status bits 2,0 show live outputs
// - disable bits 3,2 force pin reads zero
// - second disable register bit 5 likewise
// - one shared status register for all
// - new comparison each comparator clock
// - output high when positive exceeds negative
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    cmp0_raw,
  input  wire logic                    cmp2_raw,
  input  wire logic                    cmp0_vector_ack,
  input  wire logic                    cmp2_vector_ack,
  input  wire logic                    neg_pin_in,
  input  wire logic                    cmp2_pin_in,
  input  wire logic                    cmp0_pin_in,
  output logic                         neg_pin_read,
  output logic                         cmp2_pin_read,
  output logic                         cmp0_pin_read,
  output logic                         neg_pin_buf_on,
  output logic                         cmp2_pin_buf_on,
  output logic                         cmp0_pin_buf_on,
  output logic                         cmp0_power_on,
  output logic                         cmp2_power_on,
  output cmp_ctrl_pkg::neg_route_t     cmp0_route,
  output cmp_ctrl_pkg::neg_route_t     cmp2_route,
  output logic                         cmp_clk_phase,
  output logic                         cmp0_irq_req,
  output logic                         cmp2_irq_req,
  output logic                         cmp0_trigger,
  output logic                         cmp2_trigger,
  output logic                         irq
);

  cmp_ctrl_pkg::reg_req_t req;
  logic [7:0] cmp0_ctl_q;
  logic [7:0] cmp2_ctl_q;
  logic       halve_q;
  logic       flag0_q;
  logic       flag0_d;
  logic       flag2_q;
  logic       flag2_d;
  logic [7:0] dis_a_q;
  logic [7:0] dis_b_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [cmp_ctrl_pkg::EV_W-1:0] irq_st_q;
  logic [cmp_ctrl_pkg::EV_W-1:0] irq_st_d;
  logic [cmp_ctrl_pkg::EV_W-1:0] irq_en_q;
  logic [cmp_ctrl_pkg::EV_W-1:0] events;
  logic       div_q;
  logic       sample_en;
  logic       live0;
  logic       live2;
  logic       ev0;
  logic       ev2;
  logic [7:0] status_view;
  logic [7:0] ctl0_view;
  logic [7:0] ctl2_view;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction : hit

  // ==========================================================
  // address decode
  wire wr_ctl0  = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_CMP0_CONTROL);
  wire wr_ctl2  = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_CMP2_CONTROL);
  wire wr_stat  = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_STATUS);
  wire wr_dis_a = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_DISABLE_A);
  wire wr_dis_b = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_DISABLE_B);
  wire wr_iclr  = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_IRQ_CLEAR);
  wire wr_ien   = req.wr && hit(req.addr, cmp_ctrl_pkg::ADDR_IRQ_ENABLE);

  // ==========================================================
  // control registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp0_ctl_q <= cmp_ctrl_pkg::RESET_BYTE;
      cmp2_ctl_q <= cmp_ctrl_pkg::RESET_BYTE;
      halve_q    <= 1'b0;
      dis_a_q    <= cmp_ctrl_pkg::RESET_BYTE;
      dis_b_q    <= cmp_ctrl_pkg::RESET_BYTE;
      irq_en_q   <= '0;
    end
    else
    begin
      if (wr_ctl0)
        cmp0_ctl_q <= req.wdata & cmp_ctrl_pkg::CTL_WMASK;
      if (wr_ctl2)
        cmp2_ctl_q <= req.wdata & cmp_ctrl_pkg::CTL_WMASK;
      if (wr_stat)
        halve_q <= req.wdata[cmp_ctrl_pkg::ST_HALVE_BIT];
      if (wr_dis_a)
        dis_a_q <= req.wdata;
      if (wr_dis_b)
        dis_b_q <= req.wdata & cmp_ctrl_pkg::DIS_B_WMASK;
      if (wr_ien)
        irq_en_q <= req.wdata[cmp_ctrl_pkg::EV_W-1:0];
    end
  end

  assign cmp0_power_on = cmp0_ctl_q[cmp_ctrl_pkg::CTL_ON_BIT];
  assign cmp2_power_on = cmp2_ctl_q[cmp_ctrl_pkg::CTL_ON_BIT];

  // ==========================================================
  // comparator clock divider
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 1'b0;
    else
      div_q <= halve_q ? !div_q : 1'b0;
  end

  // one comparison per comparator clock period
  assign sample_en     = !halve_q || div_q;
  assign cmp_clk_phase = div_q;

  // ==========================================================
  // comparator channels
  // enable steers channel
  cmp_channel #(
    .HAS_DAC (1'b0)
  ) u_cmp0 (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .sample_en   (sample_en),
    .cmp_on      (cmp0_power_on),
    .edge_sel    (cmp0_ctl_q[cmp_ctrl_pkg::CTL_EDGE_HI:cmp_ctrl_pkg::CTL_EDGE_LO]),
    .neg_sel     (cmp0_ctl_q[cmp_ctrl_pkg::CTL_NEG_HI:cmp_ctrl_pkg::CTL_NEG_LO]),
    .raw_out     (cmp0_raw),
    .live_q      (live0),
    .event_pulse (ev0),
    .route       (cmp0_route)
  );

  cmp_channel #(
    .HAS_DAC (1'b1)
  ) u_cmp2 (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .sample_en   (sample_en),
    .cmp_on      (cmp2_power_on),
    .edge_sel    (cmp2_ctl_q[cmp_ctrl_pkg::CTL_EDGE_HI:cmp_ctrl_pkg::CTL_EDGE_LO]),
    .neg_sel     (cmp2_ctl_q[cmp_ctrl_pkg::CTL_NEG_HI:cmp_ctrl_pkg::CTL_NEG_LO]),
    .raw_out     (cmp2_raw),
    .live_q      (live2),
    .event_pulse (ev2),
    .route       (cmp2_route)
  );

  // ==========================================================
  // event flags; a new event wins over any clear
  wire ie0 = cmp0_ctl_q[cmp_ctrl_pkg::CTL_IRQ_ON_BIT];
  wire ie2 = cmp2_ctl_q[cmp_ctrl_pkg::CTL_IRQ_ON_BIT];
  wire clr0 = (wr_stat && req.wdata[cmp_ctrl_pkg::ST_FLAG0_BIT]) ||
              (cmp0_vector_ack && ie0);
  wire clr2 = (wr_stat && req.wdata[cmp_ctrl_pkg::ST_FLAG2_BIT]) ||
              (cmp2_vector_ack && ie2);

  assign flag0_d = ev0 ? 1'b1 : (clr0 ? 1'b0 : flag0_q);
  assign flag2_d = ev2 ? 1'b1 : (clr2 ? 1'b0 : flag2_q);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag0_q <= 1'b0;
      flag2_q <= 1'b0;
    end
    else
    begin
      flag0_q <= flag0_d;
      flag2_q <= flag2_d;
    end
  end

  assign cmp0_irq_req = flag0_q && ie0;
  assign cmp2_irq_req = flag2_q && ie2;
  assign cmp0_trigger = flag0_q;
  assign cmp2_trigger = flag2_q;

  // ==========================================================
  // sticky irq status, write-one clear, enable
  assign events[cmp_ctrl_pkg::EV_CMP0] = ev0;
  assign events[cmp_ctrl_pkg::EV_CMP2] = ev2;

  genvar gi;
  generate
    for (gi = 0; gi < cmp_ctrl_pkg::EV_W; gi++)
    begin : g_ist
      assign irq_st_d[gi] = events[gi] ||
                            (irq_st_q[gi] && !(wr_iclr && req.wdata[gi]));
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_st_q <= '0;
    else
      irq_st_q <= irq_st_d;
  end

  assign irq = |(irq_st_q & irq_en_q);

  // ==========================================================
  // pin buffer disables for negative, comparator 2 and comparator 0 pins
  assign neg_pin_buf_on  = !dis_a_q[cmp_ctrl_pkg::DIS_NEG_PIN_BIT];
  assign cmp2_pin_buf_on = !dis_a_q[cmp_ctrl_pkg::DIS_CMP2_PIN_BIT];
  assign neg_pin_read    = neg_pin_buf_on && neg_pin_in;
  assign cmp2_pin_read   = cmp2_pin_buf_on && cmp2_pin_in;
  assign cmp0_pin_buf_on = !dis_b_q[cmp_ctrl_pkg::DIS_CMP0_PIN_BIT];
  assign cmp0_pin_read   = cmp0_pin_buf_on && cmp0_pin_in;

  // ==========================================================
  // shared status view
  assign status_view = {halve_q, flag2_q, flag0_q, 2'b00, live2, 1'b0, live0};
  assign ctl0_view   = cmp0_ctl_q;
  assign ctl2_view   = cmp2_ctl_q;

  // read mux; unmapped and write-only read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (hit(req.addr, cmp_ctrl_pkg::ADDR_CMP0_CONTROL))
      rdata_d = ctl0_view;
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_CMP2_CONTROL))
      rdata_d = ctl2_view;
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_STATUS))
      rdata_d = status_view;
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_DISABLE_A))
      rdata_d = dis_a_q;
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_DISABLE_B))
      rdata_d = dis_b_q;
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_IRQ_STATUS))
      rdata_d = {6'h00, irq_st_q};
    else if (hit(req.addr, cmp_ctrl_pkg::ADDR_IRQ_ENABLE))
      rdata_d = {6'h00, irq_en_q};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (req.rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // assertions
  flag0_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev0 |=> flag0_q)
    else $error("comparator 0 event did not set its flag");

  flag2_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev2 |=> flag2_q)
    else $error("comparator 2 event did not set its flag");

  write_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_stat && req.wdata[cmp_ctrl_pkg::ST_FLAG0_BIT] && !ev0) |=> !flag0_q)
    else $error("write one did not clear comparator 0 flag");

  write_zero_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_stat && !req.wdata[cmp_ctrl_pkg::ST_FLAG2_BIT] && flag2_q && !cmp2_vector_ack)
    |=> flag2_q)
    else $error("write zero changed comparator 2 flag");

  vector_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmp0_vector_ack && !ie0 && flag0_q && !wr_stat) |=> flag0_q)
    else $error("vector cleared flag with interrupt disabled");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmp2_irq_req |-> (ie2 && cmp2_trigger))
    else $error("interrupt request without enable");

  halve_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (halve_q && sample_en) |=> (!sample_en || !halve_q))
    else $error("divided clock sampled twice in a row");

  pin_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dis_a_q[cmp_ctrl_pkg::DIS_NEG_PIN_BIT] |-> !neg_pin_read)
    else $error("disabled pin reads nonzero");

  pin0_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dis_b_q[cmp_ctrl_pkg::DIS_CMP0_PIN_BIT] |-> !cmp0_pin_read)
    else $error("disabled comparator 0 pin reads nonzero");

  vector_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmp2_vector_ack && ie2 && !ev2) |=> !flag2_q)
    else $error("vector entry did not clear comparator 2 flag");

  read_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && hit(req.addr, cmp_ctrl_pkg::ADDR_STATUS))
    |=> (reg_rdata[cmp_ctrl_pkg::ST_LIVE0_BIT] == $past(live0)))
    else $error("status read lost live output");

  cv_flag0_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ev0 ##1 flag0_q);
  cv_vector_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cmp2_vector_ack && ie2 && flag2_q);
  cv_irq_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
  cv_halve_ev_c: cover property (@(posedge clk_sys) disable iff (!rst_n) halve_q && ev2);

endmodule : analog_comparator_control
`default_nettype wire

// ===== verification/cmp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module cmp_core_model #(
  parameter int VREF_MV = 2560
) (
  input  wire logic                     clk_sys,
  input  wire logic                     power_on,
  input  wire cmp_ctrl_pkg::neg_route_t route,
  input  wire logic [11:0]              pos_mv,
  input  wire logic [11:0]              ext_mv,
  input  wire logic [11:0]              dac_mv,
  output logic                          raw
);
  // ==========================================================
  // negative level picked by the one-hot route
  int neg_mv;
  always_comb
  begin
    neg_mv = 4095;
    if (route.ref640) neg_mv = VREF_MV * 100 / 640;
    if (route.ref320) neg_mv = VREF_MV * 100 / 320;
    if (route.ref213) neg_mv = VREF_MV * 100 / 213;
    if (route.ref160) neg_mv = VREF_MV * 100 / 160;
    if (route.ext) neg_mv = int'(ext_mv);
    if (route.dac) neg_mv = int'(dac_mv);
  end

  // ==========================================================
  // clocked comparison; unpowered core output wanders
  initial raw = 1'b0;
  always @(negedge clk_sys)
  begin
    if (power_on)
      raw <= (int'(pos_mv) > neg_mv);
    else
      raw <= ~raw;
  end
endmodule : cmp_core_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys, rst_n, reg_wr, reg_rd, raw0, raw2, ack0, ack2, halve;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic neg_in, c2_in, c0_in, neg_rd, c2_rd, c0_rd, neg_buf, c2_buf, c0_buf;
  logic pwr0, pwr2, phase, req0, req2, trig0, trig2, irq;
  logic [11:0] pos0_mv, pos2_mv;
  cmp_ctrl_pkg::neg_route_t route0, route2;
  int num_errors, checks_done, seed;
  logic [1:0] trig_v, req_v;
  assign trig_v = {trig2, trig0};
  assign req_v  = {req2, req0};

  analog_comparator_control i_analog_comparator_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp0_raw(raw0),
    .cmp2_raw(raw2), .cmp0_vector_ack(ack0), .cmp2_vector_ack(ack2),
    .neg_pin_in(neg_in), .cmp2_pin_in(c2_in), .cmp0_pin_in(c0_in),
    .neg_pin_read(neg_rd), .cmp2_pin_read(c2_rd), .cmp0_pin_read(c0_rd),
    .neg_pin_buf_on(neg_buf), .cmp2_pin_buf_on(c2_buf), .cmp0_pin_buf_on(c0_buf),
    .cmp0_power_on(pwr0), .cmp2_power_on(pwr2), .cmp0_route(route0),
    .cmp2_route(route2), .cmp_clk_phase(phase), .cmp0_irq_req(req0),
    .cmp2_irq_req(req2), .cmp0_trigger(trig0), .cmp2_trigger(trig2), .irq(irq));
  cmp_core_model i_cmp_core_model_0 (.clk_sys(clk_sys), .power_on(pwr0), .route(route0),
    .pos_mv(pos0_mv), .ext_mv(12'h3E8), .dac_mv(12'h3E8), .raw(raw0));
  cmp_core_model i_cmp_core_model_2 (.clk_sys(clk_sys), .power_on(pwr2), .route(route2),
    .pos_mv(pos2_mv), .ext_mv(12'h3E8), .dac_mv(12'h3E8), .raw(raw2));

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(50 * 20000);
    num_errors++;
    stop_test();
  end

  // ==========================================================
  // shared tasks and expectation functions
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, exp);
  endtask : rd_chk
  task automatic set_pos(input logic c, input logic [11:0] v);
    @(posedge clk_sys);
    if (c) pos2_mv <= v;
    else pos0_mv <= v;
    repeat (12) @(posedge clk_sys);
  endtask : set_pos
  task automatic clear_all;
    reg_write(cmp_ctrl_pkg::ADDR_STATUS, {halve, 7'h60});
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_CLEAR, 8'h03);
  endtask : clear_all
  function automatic logic flag_exp(input logic [1:0] code, input logic rose);
    return (code == 2'b00) || (code == 2'b11 && rose) || (code == 2'b10 && !rose);
  endfunction : flag_exp
  function automatic logic [7:0] route_exp(input logic [2:0] k, input logic dac);
    if (k < 3'h5) return 8'h01 << k;
    return (k == 3'h5 && dac) ? 8'h20 : 8'h00;
  endfunction : route_exp

  task automatic ev_run(input logic c, input logic [1:0] code, input logic ie);
    logic [7:0] st;
    logic f;
    reg_write(c ? 4'h1 : 4'h0, {1'b1, ie, code, 4'h0});
    reg_write(c ? 4'h0 : 4'h1, 8'h00);
    set_pos(c, 12'h064);
    clear_all;
    for (int r = 1; r < 3; r++)
    begin
      set_pos(c, r[0] ? 12'hBB8 : 12'h064);
      f = flag_exp(code, r[0]);
      st = {halve, 7'h00};
      st[c ? cmp_ctrl_pkg::ST_FLAG2_BIT : cmp_ctrl_pkg::ST_FLAG0_BIT] = f;
      st[c ? cmp_ctrl_pkg::ST_LIVE2_BIT : cmp_ctrl_pkg::ST_LIVE0_BIT] = r[0];
      rd_chk(cmp_ctrl_pkg::ADDR_STATUS, st);
      rd_chk(cmp_ctrl_pkg::ADDR_IRQ_STATUS, {7'h00, f} << c);
      check({6'h00, trig_v[c], req_v[c]}, {6'h00, f, f & ie});
      clear_all;
    end
  endtask : ev_run

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial
  begin
    logic [7:0] d, da, db;
    logic p;
    seed = 32'h592B;
    {rst_n, reg_wr, reg_rd, ack0, ack2, halve, neg_in, c2_in, c0_in} = '0;
    {reg_addr, reg_wdata, num_errors, checks_done} = '0;
    pos0_mv = 12'h064;
    pos2_mv = 12'h064;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd_chk(a[3:0], 8'h00);
    check({5'h00, neg_buf, c2_buf, c0_buf}, 8'h07);
    for (int k = 0; k < 8; k++)
    begin
      d = 8'($random(seed));
      d = {1'b1, d[6:4], 1'b0, k[2:0]};
      reg_write(cmp_ctrl_pkg::ADDR_CMP0_CONTROL, d);
      reg_write(cmp_ctrl_pkg::ADDR_CMP2_CONTROL, d | 8'h08);
      rd_chk(cmp_ctrl_pkg::ADDR_CMP2_CONTROL, d & cmp_ctrl_pkg::CTL_WMASK);
      check({2'b00, route0}, route_exp(k[2:0], 1'b0));
      check({2'b00, route2}, route_exp(k[2:0], 1'b1));
      check({6'h00, pwr2, pwr0}, 8'h03);
    end
    for (int h = 0; h < 2; h++)
    begin
      halve = h[0];
      reg_write(cmp_ctrl_pkg::ADDR_STATUS, {halve, 7'h00});
      @(negedge clk_sys);
      p = phase;
      @(negedge clk_sys);
      check({7'h00, phase}, {7'h00, halve & ~p});
      for (int k = 0; k < 8; k++) ev_run(k[0], k[2:1], 1'($random(seed)));
    end
    halve = 1'b0;
    reg_write(cmp_ctrl_pkg::ADDR_STATUS, 8'h00);
    reg_write(cmp_ctrl_pkg::ADDR_CMP0_CONTROL, 8'h80);
    reg_write(cmp_ctrl_pkg::ADDR_CMP2_CONTROL, 8'h80);
    set_pos(1'b0, 12'hBB8);
    set_pos(1'b1, 12'hBB8);
    rd_chk(cmp_ctrl_pkg::ADDR_STATUS, 8'h65);
    reg_write(cmp_ctrl_pkg::ADDR_STATUS, 8'h00);
    rd_chk(cmp_ctrl_pkg::ADDR_STATUS, 8'h65);
    reg_write(cmp_ctrl_pkg::ADDR_STATUS, 8'h20);
    rd_chk(cmp_ctrl_pkg::ADDR_STATUS, 8'h45);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      ack2 <= 1'b1;
      @(posedge clk_sys);
      ack2 <= 1'b0;
      rd_chk(cmp_ctrl_pkg::ADDR_STATUS, i ? 8'h05 : 8'h45);
      reg_write(cmp_ctrl_pkg::ADDR_CMP2_CONTROL, 8'hC0);
    end
    check({7'h00, trig2}, 8'h00);
    clear_all;
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_ENABLE, 8'h00);
    set_pos(1'b0, 12'h064);
    rd_chk(cmp_ctrl_pkg::ADDR_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    @(posedge clk_sys);
    ack0 <= 1'b1;
    @(posedge clk_sys);
    ack0 <= 1'b0;
    @(negedge clk_sys);
    check({7'h00, trig0}, 8'h01);
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_ENABLE, 8'h01);
    rd_chk(cmp_ctrl_pkg::ADDR_IRQ_ENABLE, 8'h01);
    check({7'h00, irq}, 8'h01);
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_ENABLE, 8'h02);
    @(negedge clk_sys);
    check({7'h00, irq}, 8'h00);
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_ENABLE, 8'h03);
    reg_write(cmp_ctrl_pkg::ADDR_IRQ_CLEAR, 8'h01);
    @(negedge clk_sys);
    check({7'h00, irq}, 8'h00);
    reg_write(cmp_ctrl_pkg::ADDR_CMP0_CONTROL, 8'h00);
    reg_write(cmp_ctrl_pkg::ADDR_CMP2_CONTROL, 8'h0C);
    clear_all;
    set_pos(1'b0, 12'hBB8);
    set_pos(1'b1, 12'h064);
    rd_chk(cmp_ctrl_pkg::ADDR_STATUS, 8'h00);
    check({2'b00, route2}, 8'h00);
    check({2'b00, route0}, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      // random disable bits turn analog pin buffers on or off
      @(posedge clk_sys);
      {neg_in, c2_in, c0_in} <= 3'($random(seed));
      da = 8'($random(seed));
      db = 8'($random(seed));
      reg_write(cmp_ctrl_pkg::ADDR_DISABLE_A, da);
      reg_write(cmp_ctrl_pkg::ADDR_DISABLE_B, db);
      rd_chk(cmp_ctrl_pkg::ADDR_DISABLE_A, da);
      rd_chk(cmp_ctrl_pkg::ADDR_DISABLE_B, db & cmp_ctrl_pkg::DIS_B_WMASK);
      check({5'h00, neg_rd, c2_rd, c0_rd}, {5'h00, neg_in & ~da[3], c2_in & ~da[2],
        c0_in & ~db[5]});
      check({5'h00, neg_buf, c2_buf, c0_buf}, {5'h00, ~da[3], ~da[2], ~db[5]});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
